// ---- intmap_map.vh ----
/*
  register offsets, field positions, reset values and power state codes
  for the shared interrupt register bank.
  assumes: included by bare name from the design files of this block.
*/
`ifndef INTMAP_MAP_VH
`define INTMAP_MAP_VH

// shared interrupt status registers
`define OFS_MAIN_SUMMARY 8'h00
`define OFS_DEVICE_STAT 8'h01
`define OFS_HOST_STAT 8'h02
`define OFS_PROC_STAT 8'h03
`define OFS_DISK_STAT 8'h04
`define OFS_MEDIA_STAT 8'h05
// matching enable registers, sixteen above the status registers
`define OFS_MAIN_ENABLE 8'h10
`define OFS_DEVICE_EN 8'h11
`define OFS_HOST_EN 8'h12
`define OFS_PROC_EN 8'h13
`define OFS_DISK_EN 8'h14
`define OFS_MEDIA_EN 8'h15
`define ENABLE_DISTANCE 8'h10
// map side select register (chosen offset), select bit in bit 0
`define OFS_MAP_SELECT 8'h1F
`define BIT_MAP_SELECT 0
// power state register (chosen offset), read only
`define OFS_POWER_STATE 8'h1E
// windows blocked in the pll-only active state
`define BLOCK_A_LO 8'h40
`define BLOCK_A_HI 8'h47
`define BLOCK_B_LO 8'h50
`define BLOCK_B_HI 8'h6F
// first address of the side-specific upper window
`define UPPER_BASE 8'h40
// reset value of every register in the bank
`define REG_RESET 8'h00
// main summary field positions
`define SUM_DEVICE 7
`define SUM_HOST 6
`define SUM_PROC 5
`define SUM_DISK 4
`define SUM_MEDIA 3
`define SUM_FINISHED_PM 0
// valid bit masks; reserved positions read zero and never store
`define MASK_MAIN 8'hF9
`define MASK_DEVICE 8'hBF
`define MASK_HOST 8'hFF
`define MASK_PROC 8'h8F
`define MASK_DISK 8'hF7
`define MASK_MEDIA 8'h47
// power state codes
`define PS_SLEEP 3'h0
`define PS_SNOOZE 3'h1
`define PS_PLL_ONLY 3'h2
`define PS_DEV_ACTIVE 3'h3
`define PS_HOST_ACTIVE 3'h4

`endif

// ---- side_regs.v ----
/*
  one side-specific upper register map (device side or host side),
  a plain array of byte registers written only when its side is picked.
  assumes: one clock, synchronised reset, address already decoded.
*/
`timescale 1ns/1ps
`include "intmap_map.vh"

module side_regs #(
  parameter DEPTH = 64,
  parameter AW = 6
) (
  input wire core_clk,
  input wire rst_n,
  input wire wr_en,
  input wire [AW-1:0] addr,
  input wire [7:0] wdata,
  output wire [7:0] rdata
);

  reg [7:0] mem_reg [0:DEPTH-1]; // stored bytes of this map
  integer i;

  // only written when selected, so the other map keeps its contents
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem_reg[i] <= `REG_RESET;
    end
    else if (wr_en)
    begin
      mem_reg[addr] <= wdata; // RULE2
    end
  end

  // combinational read; the top registers the answer
  assign rdata = mem_reg[addr];

endmodule // side_regs

// ---- shared_register_map_interrupts.v ----
/*
  shared interrupt register bank with map side select and power state
  access gating; two side-specific upper maps hang behind it.
  assumes: one 25 MHz clock core_clk, async active-low nrst, event
  pulses from the sources on the same clock, power state from the
  power manager on the same clock.
*/
`timescale 1ns/1ps
`include "intmap_map.vh"

// What this block does
// RULE1 - select bit picks device or host map
// RULE2 - switching maps keeps both maps' contents
// RULE3 - cpu never writes one to reserved bits
// RULE4 - pll-only state blocks 0x40-0x47, 0x50-0x6F
// RULE5 - interrupt bank works in sleep and snooze
// RULE6 - other registers need an active state
// RULE7 - summary of groups, gated by enables drives irq
module shared_register_map_interrupts #(
  parameter SIDE_DEPTH = 64
) (
  input wire core_clk,
  input wire nrst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata,
  input wire [2:0] power_state,
  input wire [7:0] device_events,
  input wire [7:0] host_events,
  input wire [7:0] proc_events,
  input wire [7:0] disk_events,
  input wire [7:0] media_events,
  input wire finished_pm_event,
  output reg irq,
  output reg map_side_select,
  output reg access_refused
);

  localparam SIDE_AW = 6;

  reg rst_meta_reg; // first reset release stage
  reg rst_sync_reg; // synchronised reset used by the rest
  reg [7:0] stat_reg [1:5]; // per-group status, sticky
  reg [7:0] en_reg [0:5]; // enables, index 0 is the main enable
  reg fpm_reg; // finished power management flag
  reg [7:0] main_sum; // main summary as seen by software
  reg irq_next;
  reg [7:0] rd_next;
  reg allowed; // current access is permitted
  reg in_upper; // address falls in the side-specific window
  wire [7:0] dev_rd;
  wire [7:0] host_rd;
  wire wr_ok;
  wire [SIDE_AW-1:0] side_addr;
  integer k;

  // valid bit mask per group, applied to status updates and enable writes
  function [7:0] group_mask;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: group_mask = `MASK_MAIN;
        3'h1: group_mask = `MASK_DEVICE;
        3'h2: group_mask = `MASK_HOST;
        3'h3: group_mask = `MASK_PROC;
        3'h4: group_mask = `MASK_DISK;
        default: group_mask = `MASK_MEDIA;
      endcase
    end
  endfunction

  // blocked windows while only the pll runs
  function blocked_range;
    input [7:0] a;
    begin
      blocked_range = (a >= `BLOCK_A_LO && a <= `BLOCK_A_HI) ||
        (a >= `BLOCK_B_LO && a <= `BLOCK_B_HI);
    end
  endfunction

  // reset release through two flops, assertion stays asynchronous
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // access gating by power state
  always @*
  begin
    in_upper = (addr >= `UPPER_BASE);
    if (addr < `UPPER_BASE)
      allowed = 1'b1; // RULE5
    else if (power_state == `PS_PLL_ONLY)
      allowed = !blocked_range(addr); // RULE4
    else if (power_state == `PS_DEV_ACTIVE ||
      power_state == `PS_HOST_ACTIVE)
      allowed = 1'b1; // RULE6
    else
      allowed = 1'b0; // RULE6
  end

  assign wr_ok = wr_stb && allowed && in_upper;
  assign side_addr = addr[SIDE_AW-1:0] - 6'h00;

  // device-side map, written only while select is 0
  side_regs #(
    .DEPTH(SIDE_DEPTH),
    .AW(SIDE_AW)
  ) device_map (
    .core_clk(core_clk),
    .rst_n(rst_sync_reg),
    .wr_en(wr_ok && !map_side_select), // RULE1
    .addr(side_addr),
    .wdata(wdata),
    .rdata(dev_rd)
  );

  // host-side map, written only while select is 1
  side_regs #(
    .DEPTH(SIDE_DEPTH),
    .AW(SIDE_AW)
  ) host_map (
    .core_clk(core_clk),
    .rst_n(rst_sync_reg),
    .wr_en(wr_ok && map_side_select), // RULE1
    .addr(side_addr),
    .wdata(wdata),
    .rdata(host_rd)
  );

  // summary bits follow their groups
  always @*
  begin
    main_sum = 8'h00;
    main_sum[`SUM_DEVICE] = |(stat_reg[1] & en_reg[1]); // RULE7
    main_sum[`SUM_HOST] = |(stat_reg[2] & en_reg[2]); // RULE7
    main_sum[`SUM_PROC] = |(stat_reg[3] & en_reg[3]); // RULE7
    main_sum[`SUM_DISK] = |(stat_reg[4] & en_reg[4]); // RULE7
    main_sum[`SUM_MEDIA] = |(stat_reg[5] & en_reg[5]); // RULE7
    main_sum[`SUM_FINISHED_PM] = fpm_reg;
    irq_next = |(main_sum & en_reg[0]); // RULE7
  end

  // status: events set, writing one clears, set wins over clear;
  // enables and select are plain read/write
  always @(posedge core_clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      for (k = 1; k <= 5; k = k + 1)
        stat_reg[k] <= `REG_RESET;
      for (k = 0; k <= 5; k = k + 1)
        en_reg[k] <= `REG_RESET;
      fpm_reg <= 1'b0;
      map_side_select <= 1'b0;
    end
    else
    begin
      for (k = 1; k <= 5; k = k + 1)
      begin
        if (wr_stb && addr == `OFS_MAIN_SUMMARY + k[7:0])
          stat_reg[k] <= (stat_reg[k] & ~wdata | ev(k[2:0]))
            & group_mask(k[2:0]);
        else
          stat_reg[k] <= (stat_reg[k] | ev(k[2:0]))
            & group_mask(k[2:0]);
      end
      if (wr_stb && addr == `OFS_MAIN_SUMMARY &&
        wdata[`SUM_FINISHED_PM])
        fpm_reg <= finished_pm_event;
      else
        fpm_reg <= fpm_reg | finished_pm_event;
      for (k = 0; k <= 5; k = k + 1)
        if (wr_stb && addr == `OFS_MAIN_ENABLE + k[7:0])
          en_reg[k] <= wdata & group_mask(k[2:0]); // RULE3
      if (wr_stb && addr == `OFS_MAP_SELECT)
        map_side_select <= wdata[`BIT_MAP_SELECT]; // RULE1
    end
  end

  // event vector of one group
  function [7:0] ev;
    input [2:0] idx;
    begin
      case (idx)
        3'h1: ev = device_events;
        3'h2: ev = host_events;
        3'h3: ev = proc_events;
        3'h4: ev = disk_events;
        default: ev = media_events;
      endcase
    end
  endfunction

  // read mux, address decode by if chain
  always @*
  begin
    rd_next = 8'h00;
    if (!rd_stb || !allowed)
      rd_next = 8'h00; // RULE4
    else if (addr == `OFS_MAIN_SUMMARY)
      rd_next = main_sum;
    else if (addr >= `OFS_DEVICE_STAT && addr <= `OFS_MEDIA_STAT)
      rd_next = stat_reg[addr[2:0]];
    else if (addr >= `OFS_MAIN_ENABLE && addr <= `OFS_MEDIA_EN)
      rd_next = en_reg[addr[2:0]];
    else if (addr == `OFS_POWER_STATE)
      rd_next = {5'h00, power_state};
    else if (addr == `OFS_MAP_SELECT)
      rd_next = {7'h00, map_side_select};
    else if (in_upper && addr < `UPPER_BASE + SIDE_DEPTH)
      rd_next = map_side_select ? host_rd : dev_rd; // RULE1
    else
      rd_next = 8'h00;
  end

  // registered outputs: read data one cycle after the strobe
  always @(posedge core_clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      rdata <= 8'h00;
      irq <= 1'b0;
      access_refused <= 1'b0;
    end
    else
    begin
      rdata <= rd_next;
      irq <= irq_next;
      access_refused <= (rd_stb || wr_stb) && !allowed; // RULE6
    end
  end

endmodule // shared_register_map_interrupts

// ---- intmap_monitor.sv ----
/* checker on the bank ports.
   assumes: bound to the bank, one clock. */
`timescale 1ns/1ps
`include "intmap_map.vh"
module intmap_monitor (
  input wire core_clk,
  input wire nrst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] rdata,
  input wire [2:0] power_state,
  input wire map_side_select,
  input wire access_refused
);
  wire stb = wr_stb | rd_stb; // any access
  wire up = addr >= `UPPER_BASE; // side-specific window
  wire hi = power_state > `PS_HOST_ACTIVE;
  wire act = power_state >= `PS_PLL_ONLY && !hi;
  wire blk = addr <= `BLOCK_A_HI || (addr >= `BLOCK_B_LO &&
    addr <= `BLOCK_B_HI); // closed in pll-only state
  wire bad = up && (!act || (power_state == `PS_PLL_ONLY && blk));
  wire sel_wr = wr_stb && addr == `OFS_MAP_SELECT;
  wire sel_bit = wdata[`BIT_MAP_SELECT];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sel_write_a: assert property (sel_wr |=>
    map_side_select == $past(sel_bit)) else $error("select not stored");
  sel_hold_a: assert property (!sel_wr |=>
    $stable(map_side_select)) else $error("select moved");
  pll_block_a: assert property (stb && bad |=>
    access_refused) else $error("blocked access taken");
  shut_read_a: assert property (rd_stb && bad |=>
    rdata == 8'h00) else $error("blocked read gave data");
  low_open_a: assert property (stb && !up |=>
    !access_refused) else $error("shared access refused");
  upper_open_a: assert property (stb && up && !bad |=>
    !access_refused) else $error("active access refused");
  idle_quiet_a: assert property (!stb |=> !access_refused)
    else $error("refusal without access");
  rd_idle_a: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("read data without read");
endmodule // intmap_monitor
bind shared_register_map_interrupts intmap_monitor mon_u (
  .core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .power_state(power_state), .map_side_select(map_side_select),
  .access_refused(access_refused));

// ---- cpu_port_model.sv ----
/* cpu side of the byte register port.
   assumes: reads answer one cycle after the strobe. */
`timescale 1ns/1ps
module cpu_port_model (
  input wire core_clk,
  input wire [7:0] rdata,
  input wire access_refused,
  output reg [7:0] addr = 8'h00,
  output reg [7:0] wdata = 8'h00,
  output reg wr_stb = 1'b0,
  output reg rd_stb = 1'b0
);
  // one-cycle write; callers hand only valid bits
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
      wdata <= ~d; // stale data must not look valid
    end
  endtask
  // answer sampled once settled after the taking edge
  task rd(input [7:0] a, output [7:0] d, output r);
    begin
      @(posedge core_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1;
      d = rdata;
      r = access_refused;
    end
  endtask
endmodule // cpu_port_model

// ---- shared_register_map_interrupts_tb_top.sv ----
/* bench: reset values, map select, power gating, irq.
   assumes: cpu_port_model drives the register port. */
`timescale 1ns/1ps
`include "intmap_map.vh"
module shared_register_map_interrupts_tb_top;
  reg core_clk = 1'b0;
  reg nrst = 1'b0;
  reg [2:0] ps = `PS_DEV_ACTIVE; // power state
  reg [7:0] ev = 8'h00; // device event pulses
  wire [7:0] addr, wdata, rdata;
  wire wr_stb, rd_stb, irq, sel, refused;
  reg [7:0] d;
  reg r;
  reg [7:0] a;
  integer bad_count = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer i;
  cpu_port_model cpu_u (.core_clk(core_clk), .rdata(rdata),
    .access_refused(refused), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb));
  shared_register_map_interrupts dut_u (.core_clk(core_clk),
    .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .power_state(ps),
    .device_events(ev), .host_events(8'h00), .proc_events(8'h00),
    .disk_events(8'h00), .media_events(8'h00),
    .finished_pm_event(1'b0), .irq(irq), .map_side_select(sel),
    .access_refused(refused));
  function [7:0] msk(input integer k); // valid bits of each enable
    case (k)
      0: msk = `MASK_MAIN;
      1: msk = `MASK_DEVICE;
      2: msk = `MASK_HOST;
      3: msk = `MASK_PROC;
      4: msk = `MASK_DISK;
      default: msk = `MASK_MEDIA;
    endcase
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // read, then compare data and refusal
  task rc(input [7:0] ad, input [7:0] e, input er);
    begin
      cpu_u.rd(ad, d, r);
      chk(d, e);
      chk({7'h00, r}, {7'h00, er});
    end
  endtask
  task finish_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial
    forever #20 core_clk = ~core_clk;
  // hang guard, well above the few hundred cycles needed
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      bad_count = bad_count + 1;
      finish_test;
    end
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (i = 0; i < 6; i = i + 1)
    begin
      rc(i[7:0], `REG_RESET, 1'b0);
      rc(8'h10 + i[7:0], `REG_RESET, 1'b0);
      cpu_u.wr(8'h10 + i[7:0], msk(i));
      rc(8'h10 + i[7:0], msk(i), 1'b0);
    end
    for (i = 64; i < 128; i = i + 1)
      cpu_u.wr(i[7:0], ~i[7:0]);
    @(posedge core_clk) ps <= `PS_PLL_ONLY;
    cpu_u.wr(8'h41, 8'h00);
    for (i = 64; i < 128; i = i + 1)
    begin
      a = i[7:0];
      r = a <= `BLOCK_A_HI || (a >= `BLOCK_B_LO && a <= `BLOCK_B_HI);
      rc(a, r ? 8'h00 : ~a, r);
    end
    @(posedge core_clk) ps <= `PS_DEV_ACTIVE;
    rc(8'h41, 8'hBE, 1'b0);
    rc(`OFS_POWER_STATE, {5'h00, `PS_DEV_ACTIVE}, 1'b0);
    cpu_u.wr(`OFS_MAP_SELECT, 8'h01);
    #1;
    chk({7'h00, sel}, 8'h01);
    cpu_u.wr(8'h40, 8'h5A);
    rc(8'h40, 8'h5A, 1'b0);
    cpu_u.wr(`OFS_MAP_SELECT, 8'h00);
    rc(8'h40, 8'hBF, 1'b0);
    for (i = 0; i < 3; i = i + 1)
    begin
      @(posedge core_clk) ps <= (i == 2) ? 3'h5 : i[2:0];
      cpu_u.wr(8'h40, 8'h77);
      rc(8'h40, 8'h00, 1'b1);
      rc(`OFS_DEVICE_EN, `MASK_DEVICE, 1'b0);
    end
    @(posedge core_clk) ps <= `PS_DEV_ACTIVE;
    rc(8'h40, 8'hBF, 1'b0);
    @(posedge core_clk) ev <= 8'h01;
    @(posedge core_clk) ev <= 8'h00;
    repeat (3) @(posedge core_clk);
    chk({7'h00, irq}, 8'h01);
    rc(`OFS_DEVICE_STAT, 8'h01, 1'b0);
    rc(`OFS_MAIN_SUMMARY, 8'h80, 1'b0);
    cpu_u.wr(`OFS_MAIN_ENABLE, 8'h00);
    repeat (3) @(posedge core_clk);
    chk({7'h00, irq}, 8'h00);
    cpu_u.wr(`OFS_MAIN_ENABLE, 8'h80);
    repeat (3) @(posedge core_clk);
    chk({7'h00, irq}, 8'h01);
    cpu_u.wr(`OFS_DEVICE_STAT, 8'h01);
    repeat (3) @(posedge core_clk);
    chk({7'h00, irq}, 8'h00);
    rc(`OFS_DEVICE_STAT, 8'h00, 1'b0);
    finish_test;
  end
endmodule // shared_register_map_interrupts_tb_top
